/* File: src/rbx_pkg.sv */
package rbx_pkg;
   // Datapath sizes
   localparam int unsigned WORD_W = 16;
   localparam int unsigned ACC_W = 36;
   localparam int unsigned STK_AW = 6;
   localparam int unsigned NUM_ACC = 4;
   localparam int unsigned NUM_IRQ = 3;
   // Register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_IMM = 8'h04;
   localparam logic [7:0] OFS_PC = 8'h08;
   localparam logic [7:0] OFS_SP = 8'h0c;
   localparam logic [7:0] OFS_ST0 = 8'h10;
   localparam logic [7:0] OFS_ST1 = 8'h14;
   localparam logic [7:0] OFS_STK_ADDR = 8'h18;
   localparam logic [7:0] OFS_STK_DATA = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [1:0] ACC_REGION = 2'h1;
   // Status word field positions
   localparam int unsigned F_Z = 15;
   localparam int unsigned F_M = 14;
   localparam int unsigned F_C = 11;
   localparam int unsigned F_IE = 4;
   // Reset values
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [15:0] SP_RST = 16'h0000;
   localparam logic [15:0] ST_RST = 16'h0000;
   // Arithmetic constants
   localparam logic [35:0] ROUND_K = 36'h0_0000_8000;
   localparam logic [15:0] SP_STEP = 16'h0001;
   // Execution cycle counts
   localparam logic [1:0] CYC_RET = 2'h1;
   localparam logic [1:0] CYC_DLY = 2'h1;
   localparam logic [1:0] CYC_RETI_SKIP = 2'h2;
   localparam logic [1:0] CYC_RETI_DO = 2'h3;
   localparam logic [1:0] CYC_RETS = 2'h3;
   localparam logic [1:0] CYC_BF = 2'h2;
   localparam logic [1:0] CYC_ACC = 2'h1;
   localparam logic [1:0] DLY_SLOTS = 2'h2;
   // Bit-field targets
   localparam logic [2:0] TGT_ST0 = 3'h0;
   localparam logic [2:0] TGT_ST1 = 3'h1;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      OP_NOP, OP_RET, OP_RETD, OP_RETI, OP_RETID, OP_RETS,
      OP_RND, OP_ROL, OP_ROR, OP_RST, OP_SET
   } rbx_op_type;

   typedef enum logic [1:0] {
      COND_ALWAYS, COND_ZSET, COND_ZCLR, COND_CSET
   } rbx_cond_type;

   // Command word layout, low ten bits of the command register
   typedef struct packed {
      logic [2:0] tgt;
      logic ctx;
      rbx_cond_type cond;
      rbx_op_type op;
   } rbx_cmd_type;

   typedef struct packed {
      logic take;
      logic [1:0] src;
   } rbx_irq_type;
endpackage : rbx_pkg

/* File: src/rbx_exec.sv */
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Taken conditional return loads pc from stack top, then sp grows by one.
// - Delayed return holds stack word, bumps sp, runs two slots, then loads pc.
// - Interrupts are blocked during a delayed exit and its two slots.
// - Taken interrupt return pops pc, bumps sp, sets the interrupt gate when leaving a maskable service.
// - Interrupt return takes two cycles when skipped, three when taken.
// - Interrupt returns set the gate only when leaving a maskable service.
// - Taken interrupt return with context option pulses the context switch.
// - Delayed interrupt return holds word, bumps sp, sets gate when leaving a maskable service, then loads.
// - Parameter-drop return loads pc, adds one plus low immediate byte to sp, 3 cycles.
// - Parameter-drop return leaves the interrupt gate unchanged.
// - Rotate left goes through carry; top bit becomes new carry.
// - Rotate right goes through carry; low bit becomes new carry.
// - Bit-field clear ands operand with inverted 16-bit mask, no extension.
// - Bit-field set ors operand with 16-bit mask.
// - Clearing status word 0 clears exactly the masked bits, flags too.
// - Bit-field writes change only the addressed accumulator part.
// - Bit-field on status word 1 updates flags from the result.
module rbx_exec (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus, write side
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Register bus, read side
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt request pins
   input wire logic maskable_irq_0,
   input wire logic maskable_irq_1,
   input wire logic maskable_irq_2,
   // Core side
   output rbx_pkg::rbx_irq_type irq_out,
   output logic ctx_switch,
   output logic maskable_irq_gate
);
   logic [15:0] pc_ff, nxt_pc, sp_ff, nxt_sp, held_ff, nxt_held;
   logic [15:0] imm_ff, nxt_imm;
   logic [15:4] st0_ff, nxt_st0, st1_ff, nxt_st1;
   logic [35:0] acc_ff [rbx_pkg::NUM_ACC];
   logic [35:0] nxt_acc [rbx_pkg::NUM_ACC];
   logic [15:0] stk_mem [2**rbx_pkg::STK_AW];
   logic [5:0] stka_ff, nxt_stka;
   logic [1:0] cnt_ff, nxt_cnt, left_ff, nxt_left;
   logic dly_ff, nxt_dly, isr_ff, nxt_isr, ctx_ff, nxt_ctx;
   logic [2:0] pend_ff, nxt_pend, sync1_ff, sync2_ff, prev_ff;
   rbx_pkg::rbx_irq_type irq_ff, nxt_irq;
   logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
   logic [7:0] awa_ff, nxt_awa;
   logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
   logic [3:0] ws_ff, nxt_ws;
   logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
   logic stk_we;
   logic [15:0] stk_wdata;
   logic [5:0] stk_waddr;
   logic [15:0] st0_view, st1_view, stk_top;
   logic busy, do_wr, start;
   logic [2:0] rise;

   assign busy = (cnt_ff != 2'h0);
   assign st0_view = {st0_ff, acc_ff[0][35:32]};
   assign st1_view = {st1_ff, acc_ff[1][35:32]};
   assign stk_top = stk_mem[sp_ff[rbx_pkg::STK_AW-1:0]];
   assign rise = sync2_ff & ~prev_ff;
   // Command writes wait out a running command
   assign do_wr = aw_ff && w_ff && !bv_ff &&
                  !(awa_ff == rbx_pkg::OFS_CMD && busy);
   assign s_axi_awready = !aw_ff;
   assign s_axi_wready = !w_ff;
   assign s_axi_bvalid = bv_ff;
   assign s_axi_bresp = br_ff;
   assign s_axi_arready = !rv_ff;
   assign s_axi_rvalid = rv_ff;
   assign s_axi_rdata = rd_ff;
   assign s_axi_rresp = rr_ff;
   assign irq_out = irq_ff;
   assign ctx_switch = ctx_ff;
   assign maskable_irq_gate = st0_ff[rbx_pkg::F_IE];

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = wd[7:0];
      end
      if (strb[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction : merge

   // Bus channels
   always_comb begin
      nxt_aw = aw_ff;
      nxt_awa = awa_ff;
      nxt_w = w_ff;
      nxt_wd = wd_ff;
      nxt_ws = ws_ff;
      nxt_bv = bv_ff;
      nxt_br = br_ff;
      nxt_rv = rv_ff;
      nxt_rd = rd_ff;
      nxt_rr = rr_ff;
      if (s_axi_awvalid && !aw_ff) begin
         nxt_aw = 1'b1;
         nxt_awa = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_ff) begin
         nxt_w = 1'b1;
         nxt_wd = s_axi_wdata;
         nxt_ws = s_axi_wstrb;
      end
      if (bv_ff && s_axi_bready) begin
         nxt_bv = 1'b0;
      end
      if (do_wr) begin
         nxt_aw = 1'b0;
         nxt_w = 1'b0;
         nxt_bv = 1'b1;
         nxt_br = (awa_ff <= rbx_pkg::OFS_STK_DATA ||
                   (awa_ff[7:6] == rbx_pkg::ACC_REGION && !awa_ff[5])) ?
                  rbx_pkg::RESP_OKAY : rbx_pkg::RESP_SLVERR;
      end
      if (rv_ff && s_axi_rready) begin
         nxt_rv = 1'b0;
      end
      if (s_axi_arvalid && !rv_ff) begin
         nxt_rv = 1'b1;
         nxt_rr = rbx_pkg::RESP_OKAY;
         nxt_rd = 32'h0000_0000;
         case ({s_axi_araddr[7:2], 2'b00})
            rbx_pkg::OFS_CMD: nxt_rd = 32'h0000_0000;
            rbx_pkg::OFS_IMM: nxt_rd = {16'h0000, imm_ff};
            rbx_pkg::OFS_PC: nxt_rd = {16'h0000, pc_ff};
            rbx_pkg::OFS_SP: nxt_rd = {16'h0000, sp_ff};
            rbx_pkg::OFS_ST0: nxt_rd = {16'h0000, st0_view};
            rbx_pkg::OFS_ST1: nxt_rd = {16'h0000, st1_view};
            rbx_pkg::OFS_STK_ADDR: nxt_rd = {26'h000_0000, stka_ff};
            rbx_pkg::OFS_STK_DATA: nxt_rd = {16'h0000, stk_mem[stka_ff]};
            rbx_pkg::OFS_STATUS: nxt_rd = {24'h00_0000, isr_ff, pend_ff,
                                           left_ff, dly_ff, busy};
            default: begin
               if (s_axi_araddr[7:6] == rbx_pkg::ACC_REGION &&
                   !s_axi_araddr[5]) begin
                  nxt_rd = s_axi_araddr[2] ?
                     {28'h000_0000, acc_ff[s_axi_araddr[4:3]][35:32]} :
                     acc_ff[s_axi_araddr[4:3]][31:0];
               end else begin
                  nxt_rr = rbx_pkg::RESP_SLVERR;
               end
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ff <= 1'b0;
         awa_ff <= 8'h00;
         w_ff <= 1'b0;
         wd_ff <= 32'h0000_0000;
         ws_ff <= 4'h0;
         bv_ff <= 1'b0;
         br_ff <= 2'h0;
         rv_ff <= 1'b0;
         rd_ff <= 32'h0000_0000;
         rr_ff <= 2'h0;
      end else begin
         aw_ff <= nxt_aw;
         awa_ff <= nxt_awa;
         w_ff <= nxt_w;
         wd_ff <= nxt_wd;
         ws_ff <= nxt_ws;
         bv_ff <= nxt_bv;
         br_ff <= nxt_br;
         rv_ff <= nxt_rv;
         rd_ff <= nxt_rd;
         rr_ff <= nxt_rr;
      end
   end

   // Core state
   always_comb begin
      rbx_pkg::rbx_cmd_type cmd;
      logic cond_ok, fin;
      logic [1:0] cyc, ai;
      logic [15:0] opd, res;
      logic [35:0] a;
      logic [2:0] clr;
      cmd = rbx_pkg::rbx_cmd_type'(wd_ff[9:0]);
      cond_ok = 1'b1;
      fin = 1'b0;
      cyc = rbx_pkg::CYC_ACC;
      ai = cmd.tgt[2:1] - 2'h1;
      opd = 16'h0000;
      res = 16'h0000;
      a = acc_ff[cmd.tgt[1:0]];
      clr = 3'h0;
      start = 1'b0;
      nxt_pc = pc_ff;
      nxt_sp = sp_ff;
      nxt_held = held_ff;
      nxt_imm = imm_ff;
      nxt_st0 = st0_ff;
      nxt_st1 = st1_ff;
      nxt_acc = acc_ff;
      nxt_stka = stka_ff;
      nxt_cnt = busy ? cnt_ff - 2'h1 : 2'h0;
      nxt_left = left_ff;
      nxt_dly = dly_ff;
      nxt_isr = isr_ff;
      nxt_ctx = 1'b0;
      nxt_irq = '{take: 1'b0, src: irq_ff.src};
      stk_we = 1'b0;
      stk_waddr = stka_ff;
      stk_wdata = merge(stk_mem[stka_ff], wd_ff, ws_ff);
      case (cmd.cond)
         rbx_pkg::COND_ZSET: cond_ok = st0_ff[rbx_pkg::F_Z];
         rbx_pkg::COND_ZCLR: cond_ok = !st0_ff[rbx_pkg::F_Z];
         rbx_pkg::COND_CSET: cond_ok = st0_ff[rbx_pkg::F_C];
         default: cond_ok = 1'b1;
      endcase
      if (do_wr) begin
         case (awa_ff)
            rbx_pkg::OFS_CMD: start = 1'b1;
            rbx_pkg::OFS_IMM: nxt_imm = merge(imm_ff, wd_ff, ws_ff);
            rbx_pkg::OFS_PC: nxt_pc = merge(pc_ff, wd_ff, ws_ff);
            rbx_pkg::OFS_SP: nxt_sp = merge(sp_ff, wd_ff, ws_ff);
            rbx_pkg::OFS_ST0: begin
               res = merge(st0_view, wd_ff, ws_ff);
               nxt_st0 = res[15:4];
               nxt_acc[0][35:32] = res[3:0];
            end
            rbx_pkg::OFS_ST1: begin
               res = merge(st1_view, wd_ff, ws_ff);
               nxt_st1 = res[15:4];
               nxt_acc[1][35:32] = res[3:0];
            end
            rbx_pkg::OFS_STK_ADDR: nxt_stka = wd_ff[5:0];
            rbx_pkg::OFS_STK_DATA: stk_we = 1'b1;
            default: begin
               if (awa_ff[7:6] == rbx_pkg::ACC_REGION && !awa_ff[5]) begin
                  if (awa_ff[2] && ws_ff[0]) begin
                     nxt_acc[awa_ff[4:3]][35:32] = wd_ff[3:0];
                  end else if (!awa_ff[2]) begin
                     nxt_acc[awa_ff[4:3]][31:0] = {
                        merge(acc_ff[awa_ff[4:3]][31:16], {16'h0000,
                              wd_ff[31:16]}, {2'b00, ws_ff[3:2]}),
                        merge(acc_ff[awa_ff[4:3]][15:0], wd_ff, ws_ff)};
                  end
               end
            end
         endcase
      end
      if (start) begin
         case (cmd.op)
            rbx_pkg::OP_RET: begin
               cyc = rbx_pkg::CYC_RET;
               if (cond_ok) begin
                  nxt_pc = stk_top;
                  nxt_sp = sp_ff + rbx_pkg::SP_STEP;
               end
            end
            rbx_pkg::OP_RETD, rbx_pkg::OP_RETID: begin
               cyc = rbx_pkg::CYC_DLY;
               nxt_held = stk_top;
               nxt_sp = sp_ff + rbx_pkg::SP_STEP;
               nxt_dly = 1'b1;
               nxt_left = rbx_pkg::DLY_SLOTS;
               if (cmd.op == rbx_pkg::OP_RETID) begin
                  nxt_isr = 1'b0;
                  if (isr_ff) begin
                     nxt_st0[rbx_pkg::F_IE] = 1'b1;
                  end
               end
            end
            rbx_pkg::OP_RETI: begin
               cyc = cond_ok ? rbx_pkg::CYC_RETI_DO :
                               rbx_pkg::CYC_RETI_SKIP;
               if (cond_ok) begin
                  nxt_pc = stk_top;
                  nxt_sp = sp_ff + rbx_pkg::SP_STEP;
                  nxt_isr = 1'b0;
                  nxt_ctx = cmd.ctx;
                  if (isr_ff) begin
                     nxt_st0[rbx_pkg::F_IE] = 1'b1;
                  end
               end
            end
            rbx_pkg::OP_RETS: begin
               // Gate untouched
               cyc = rbx_pkg::CYC_RETS;
               nxt_pc = stk_top;
               nxt_sp = sp_ff + rbx_pkg::SP_STEP +
                        {8'h00, imm_ff[7:0]};
            end
            rbx_pkg::OP_RND, rbx_pkg::OP_ROL, rbx_pkg::OP_ROR: begin
               if (cond_ok) begin
                  if (cmd.op == rbx_pkg::OP_RND) begin
                     a = acc_ff[cmd.tgt[1:0]] + rbx_pkg::ROUND_K;
                  end else if (cmd.op == rbx_pkg::OP_ROL) begin
                     a = {acc_ff[cmd.tgt[1:0]][34:0],
                          st0_ff[rbx_pkg::F_C]};
                     nxt_st0[rbx_pkg::F_C] =
                        acc_ff[cmd.tgt[1:0]][35];
                  end else begin
                     a = {st0_ff[rbx_pkg::F_C],
                          acc_ff[cmd.tgt[1:0]][35:1]};
                     nxt_st0[rbx_pkg::F_C] =
                        acc_ff[cmd.tgt[1:0]][0];
                  end
                  nxt_acc[cmd.tgt[1:0]] = a;
                  nxt_st0[rbx_pkg::F_Z] = (a == 36'h0_0000_0000);
                  nxt_st0[rbx_pkg::F_M] = a[35];
               end
            end
            rbx_pkg::OP_RST, rbx_pkg::OP_SET: begin
               cyc = rbx_pkg::CYC_BF;
               case (cmd.tgt)
                  rbx_pkg::TGT_ST0: opd = st0_view;
                  rbx_pkg::TGT_ST1: opd = st1_view;
                  default: opd = cmd.tgt[0] ? acc_ff[ai][31:16] :
                                              acc_ff[ai][15:0];
               endcase
               res = (cmd.op == rbx_pkg::OP_RST) ? (opd & ~imm_ff) :
                     (opd | imm_ff);
               if (cmd.tgt == rbx_pkg::TGT_ST0) begin
                  nxt_st0 = res[15:4];
                  nxt_acc[0][35:32] = res[3:0];
               end else begin
                  if (cmd.tgt == rbx_pkg::TGT_ST1) begin
                     nxt_st1 = res[15:4];
                     nxt_acc[1][35:32] = res[3:0];
                  end else if (cmd.tgt[0]) begin
                     nxt_acc[ai][31:16] = res;
                  end else begin
                     nxt_acc[ai][15:0] = res;
                  end
                  nxt_st0[rbx_pkg::F_Z] = (res == 16'h0000);
                  nxt_st0[rbx_pkg::F_M] = res[15];
               end
            end
            default: cyc = rbx_pkg::CYC_ACC;
         endcase
         nxt_cnt = cyc - 2'h1;
         if (dly_ff) begin
            nxt_left = (left_ff > cyc) ? left_ff - cyc : 2'h0;
         end
      end
      fin = (start && cyc == 2'h1) || cnt_ff == 2'h1;
      if (fin && dly_ff && nxt_left == 2'h0) begin
         nxt_pc = held_ff;
         nxt_dly = 1'b0;
      end
      // Accept outside any running or delayed sequence
      if (!busy && !start && !dly_ff && st0_ff[rbx_pkg::F_IE] &&
          pend_ff != 3'h0) begin
         nxt_st0[rbx_pkg::F_IE] = 1'b0;
         nxt_isr = 1'b1;
         nxt_irq.take = 1'b1;
         nxt_irq.src = pend_ff[0] ? 2'h0 : (pend_ff[1] ? 2'h1 : 2'h2);
         clr[nxt_irq.src] = 1'b1;
      end
      // New edge beats the accept clear
      nxt_pend = (pend_ff & ~clr) | rise;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_ff <= rbx_pkg::PC_RST;
         sp_ff <= rbx_pkg::SP_RST;
         held_ff <= 16'h0000;
         imm_ff <= 16'h0000;
         st0_ff <= rbx_pkg::ST_RST[15:4];
         st1_ff <= rbx_pkg::ST_RST[15:4];
         acc_ff <= '{default: 36'h0_0000_0000};
         stka_ff <= 6'h00;
         cnt_ff <= 2'h0;
         left_ff <= 2'h0;
         dly_ff <= 1'b0;
         isr_ff <= 1'b0;
         ctx_ff <= 1'b0;
         irq_ff <= '{take: 1'b0, src: 2'h0};
         pend_ff <= 3'h0;
         sync1_ff <= 3'h0;
         sync2_ff <= 3'h0;
         prev_ff <= 3'h0;
      end else begin
         pc_ff <= nxt_pc;
         sp_ff <= nxt_sp;
         held_ff <= nxt_held;
         imm_ff <= nxt_imm;
         st0_ff <= nxt_st0;
         st1_ff <= nxt_st1;
         acc_ff <= nxt_acc;
         stka_ff <= nxt_stka;
         cnt_ff <= nxt_cnt;
         left_ff <= nxt_left;
         dly_ff <= nxt_dly;
         isr_ff <= nxt_isr;
         ctx_ff <= nxt_ctx;
         irq_ff <= nxt_irq;
         pend_ff <= nxt_pend;
         sync1_ff <= {maskable_irq_2, maskable_irq_1, maskable_irq_0};
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
      end
   end

   // Stack has no reset; software loads it first
   always_ff @(posedge aclk) begin
      if (stk_we) begin
         stk_mem[stk_waddr] <= stk_wdata;
      end
   end
endmodule : rbx_exec
`default_nettype wire

/* File: verif/rbx_exec_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module rbx_exec_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus answers
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Core side
   input wire rbx_pkg::rbx_irq_type irq_out,
   input wire logic ctx_switch,
   input wire logic maskable_irq_gate
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_take_gate_open: assert property (irq_out.take |->
      $past(maskable_irq_gate) && !maskable_irq_gate)
      else $error("interrupt taken while gate shut");
   a_take_one_pulse: assert property (irq_out.take |=> !irq_out.take)
      else $error("accept pulse too long");
   a_take_src_legal: assert property (irq_out.take |-> irq_out.src < 2'h3)
      else $error("accept source out of range");
   a_ctx_one_pulse: assert property (ctx_switch |=> !ctx_switch)
      else $error("context pulse too long");
   a_ctx_by_write: assert property (ctx_switch |->
      s_axi_bvalid || $past(s_axi_bvalid))
      else $error("context pulse without command");
   a_gate_by_write: assert property ($rose(maskable_irq_gate) |->
      s_axi_bvalid || $past(s_axi_bvalid))
      else $error("gate opened without command");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
endmodule : rbx_exec_chk
bind rbx_exec rbx_exec_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .irq_out(irq_out), .ctx_switch(ctx_switch),
   .maskable_irq_gate(maskable_irq_gate));
`default_nettype wire

/* File: verif/test_return_bitfield_exec.sv */
`timescale 1ns/100ps
`default_nettype none
module test_return_bitfield_exec;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [2:0] irq = 3'h0;
   logic awready, wready, bvalid, arready, rvalid, ctx, gate;
   logic [1:0] bresp, rresp, rd_r, last_src;
   logic [31:0] rdata, rd_v;
   rbx_pkg::rbx_irq_type irq_out;
   int fail_count = 0;
   int cmp_count = 0;
   int takes = 0;
   int ctxs = 0;

   rbx_exec DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .maskable_irq_0(irq[0]), .maskable_irq_1(irq[1]),
      .maskable_irq_2(irq[2]), .irq_out(irq_out), .ctx_switch(ctx),
      .maskable_irq_gate(gate));

   initial begin
      forever #50 aclk = ~aclk;
   end

   // Pulses counted where settled
   always @(negedge aclk) begin
      if (irq_out.take === 1'b1) begin
         takes++;
         last_src = irq_out.src;
      end
      if (ctx === 1'b1) begin
         ctxs++;
      end
   end

   task automatic test_done;
      $display("Checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask : chk

   task automatic hang;
      fail_count++;
      $display("BAD bus expected 1 seen 0");
      test_done();
   endtask : hang

   // Judged at the falling edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ta, tw, tb;
      n = 0;
      tb = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!tb) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         rd_r = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         bready <= bvalid && !tb;
         n++;
         if (n > 200) hang();
      end
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int n;
      logic ta, tr;
      n = 0;
      tr = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!tr) begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid && rready;
         rd_v = rdata;
         rd_r = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         rready <= rvalid && !tr;
         n++;
         if (n > 200) hang();
      end
   endtask : rd

   task automatic rdc(input string n, input logic [7:0] a,
                      input logic [31:0] e);
      rd(a);
      chk(n, e, rd_v);
   endtask : rdc

   task automatic cmd(input logic [3:0] op, input logic [1:0] cnd,
                      input logic cx, input logic [2:0] tg);
      wr(rbx_pkg::OFS_CMD, {22'h0, tg, cx, cnd, op});
   endtask : cmd

   task automatic stk(input logic [5:0] i, input logic [15:0] w);
      wr(rbx_pkg::OFS_STK_ADDR, {26'h0, i});
      wr(rbx_pkg::OFS_STK_DATA, {16'h0, w});
   endtask : stk

   task automatic wait_take(input int k);
      int n;
      n = 0;
      while (takes < k && n < 30) begin
         @(posedge aclk);
         n++;
      end
      chk("take count", k, takes);
      if (takes != k) test_done();
   endtask : wait_take

   task automatic t_ret;
      stk(6'h0, 16'h1234);
      wr(rbx_pkg::OFS_SP, 32'h0);
      cmd(rbx_pkg::OP_RET, 2'h1, 1'b0, 3'h0);
      rdc("pc skipped", rbx_pkg::OFS_PC, 32'h0);
      cmd(rbx_pkg::OP_RET, 2'h0, 1'b0, 3'h0);
      rdc("pc", rbx_pkg::OFS_PC, 32'h1234);
      rdc("sp", rbx_pkg::OFS_SP, 32'h1);
      $display("Test ret done");
   endtask : t_ret

   task automatic t_retd;
      stk(6'h1, 16'h0abc);
      wr(rbx_pkg::OFS_ST0, 32'h10);
      cmd(rbx_pkg::OP_RETD, 2'h0, 1'b0, 3'h0);
      rdc("status slots", rbx_pkg::OFS_STATUS, 32'h0a);
      irq <= 3'h2;
      repeat (4) @(posedge aclk);
      irq <= 3'h0;
      repeat (4) @(posedge aclk);
      chk("blocked", 0, takes);
      rdc("status pend", rbx_pkg::OFS_STATUS, 32'h2a);
      rdc("pc held", rbx_pkg::OFS_PC, 32'h1234);
      cmd(rbx_pkg::OP_NOP, 2'h0, 1'b0, 3'h0);
      cmd(rbx_pkg::OP_NOP, 2'h0, 1'b0, 3'h0);
      rdc("pc retd", rbx_pkg::OFS_PC, 32'h0abc);
      rdc("sp retd", rbx_pkg::OFS_SP, 32'h2);
      wait_take(1);
      chk("src", 32'h1, {30'h0, last_src});
      $display("Test retd done");
   endtask : t_retd

   task automatic t_reti;
      stk(6'h2, 16'h0200);
      cmd(rbx_pkg::OP_RETI, 2'h0, 1'b1, 3'h0);
      rdc("pc reti", rbx_pkg::OFS_PC, 32'h0200);
      rdc("sp reti", rbx_pkg::OFS_SP, 32'h3);
      chk("gate set", 32'h1, {31'h0, gate});
      chk("ctx", 32'h1, ctxs);
      cmd(rbx_pkg::OP_RETI, 2'h1, 1'b1, 3'h0);
      rdc("pc skip", rbx_pkg::OFS_PC, 32'h0200);
      chk("ctx skip", 32'h1, ctxs);
      wr(rbx_pkg::OFS_ST0, 32'h0);
      stk(6'h3, 16'h0300);
      cmd(rbx_pkg::OP_RETI, 2'h0, 1'b0, 3'h0);
      rdc("pc plain", rbx_pkg::OFS_PC, 32'h0300);
      chk("gate kept", 32'h0, {31'h0, gate});
      chk("ctx none", 32'h1, ctxs);
      $display("Test reti done");
   endtask : t_reti

   task automatic t_rets;
      wr(rbx_pkg::OFS_ST0, 32'h10);
      irq <= 3'h1;
      repeat (4) @(posedge aclk);
      irq <= 3'h0;
      wait_take(2);
      stk(6'h4, 16'h0777);
      wr(rbx_pkg::OFS_IMM, 32'h3f);
      cmd(rbx_pkg::OP_RETS, 2'h0, 1'b0, 3'h0);
      rdc("pc rets", rbx_pkg::OFS_PC, 32'h0777);
      rdc("sp rets", rbx_pkg::OFS_SP, 32'h44);
      chk("gate rets", 32'h0, {31'h0, gate});
      cmd(rbx_pkg::OP_RETID, 2'h0, 1'b0, 3'h0);
      chk("gate id", 32'h1, {31'h0, gate});
      $display("Test rets done");
   endtask : t_rets

   task automatic t_acc;
      wr(8'h40, 32'h8123);
      wr(8'h44, 32'h0);
      cmd(rbx_pkg::OP_RND, 2'h0, 1'b0, 3'h0);
      rdc("rnd", 8'h40, 32'h0001_0123);
      wr(rbx_pkg::OFS_ST0, 32'h0);
      wr(8'h48, 32'h1);
      wr(8'h4c, 32'h8);
      cmd(rbx_pkg::OP_ROL, 2'h0, 1'b0, 3'h1);
      rdc("rol lo", 8'h48, 32'h2);
      rdc("rol hi", 8'h4c, 32'h0);
      rd(rbx_pkg::OFS_ST0);
      chk("rol c", 32'h1, {31'h0, rd_v[rbx_pkg::F_C]});
      cmd(rbx_pkg::OP_ROR, 2'h0, 1'b0, 3'h1);
      rdc("ror hi", 8'h4c, 32'h8);
      rd(rbx_pkg::OFS_ST0);
      chk("ror c", 32'h0, {31'h0, rd_v[rbx_pkg::F_C]});
      cmd(rbx_pkg::OP_ROL, 2'h3, 1'b0, 3'h1);
      rdc("rol cond", 8'h48, 32'h1);
      $display("Test acc done");
   endtask : t_acc

   task automatic t_bitf;
      wr(rbx_pkg::OFS_ST1, 32'h5);
      wr(rbx_pkg::OFS_IMM, 32'h5);
      cmd(rbx_pkg::OP_RST, 2'h0, 1'b0, rbx_pkg::TGT_ST1);
      rdc("st1 clr", rbx_pkg::OFS_ST1, 32'h0);
      rd(rbx_pkg::OFS_ST0);
      chk("z flag", 32'h1, {31'h0, rd_v[rbx_pkg::F_Z]});
      wr(8'h50, 32'h1234_0000);
      wr(8'h54, 32'h3);
      wr(rbx_pkg::OFS_IMM, 32'hff);
      cmd(rbx_pkg::OP_SET, 2'h0, 1'b0, 3'h6);
      rdc("set lo", 8'h50, 32'h1234_00ff);
      rdc("set hi", 8'h54, 32'h3);
      wr(rbx_pkg::OFS_ST0, 32'hc81f);
      wr(rbx_pkg::OFS_IMM, 32'h8811);
      cmd(rbx_pkg::OP_RST, 2'h0, 1'b0, rbx_pkg::TGT_ST0);
      rdc("st0 clr", rbx_pkg::OFS_ST0, 32'h400e);
      rd(8'h3c);
      chk("unmapped", {30'h0, rbx_pkg::RESP_SLVERR}, {30'h0, rd_r});
      wr(8'h3c, 32'h1);
      chk("bresp", {30'h0, rbx_pkg::RESP_SLVERR}, {30'h0, rd_r});
      $display("Test bitfield done");
   endtask : t_bitf

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_ret();
      t_retd();
      t_reti();
      t_rets();
      t_acc();
      t_bitf();
      test_done();
   end
endmodule : test_return_bitfield_exec
`default_nettype wire
